// >>> src/panel_link_pkg.sv
package panel_link_pkg;

    // ****************************************************************
    // Clock and link geometry
    // ****************************************************************
    localparam real CLK_HZ = 10.0e6;
    localparam int PIXEL_BITS = 24;
    localparam int LINE_ACTIVE_CLOCKS = 960;
    localparam int LINE_BLANK_MIN = 86;
    localparam int LINE_BLANK_TYP = 140;
    localparam int LINE_BLANK_MAX = 214;
    localparam int FRAME_ACTIVE_LINES = 1080;
    localparam int FRAME_BLANK_MIN = 12;
    localparam int FRAME_BLANK_TYP = 45;
    localparam int FRAME_BLANK_MAX = 300;
    localparam int HCOUNT_BITS = 11;
    localparam int VCOUNT_BITS = 11;

    // ****************************************************************
    // Power sequence times, in ms as printed, and their cycle counts
    // ****************************************************************
    localparam real SUPPLY_RISE_MS = 10.0;
    localparam real LINK_STOP_MS = 50.0;
    localparam real MIN_POWER_OFF_INTERVAL_MS = 1000.0;
    localparam real LIGHT_DELAY_MS = 500.0;
    localparam real DIM_DELAY_MS = 100.0;
    localparam int SUPPLY_RISE_CYC = int'($floor(SUPPLY_RISE_MS * CLK_HZ / 1000.0));
    localparam int LINK_STOP_CYC = int'($ceil(LINK_STOP_MS * CLK_HZ / 1000.0));
    localparam int POWER_OFF_CYC =
        int'($ceil(MIN_POWER_OFF_INTERVAL_MS * CLK_HZ / 1000.0));
    localparam int LIGHT_DELAY_CYC = int'($ceil(LIGHT_DELAY_MS * CLK_HZ / 1000.0));
    localparam int DIM_DELAY_CYC = int'($ceil(DIM_DELAY_MS * CLK_HZ / 1000.0));
    localparam int WAIT_BITS = 24;

    // ****************************************************************
    // Backlight dimming
    // ****************************************************************
    localparam real DIM_PWM_HZ = 1000.0;
    localparam int DUTY_STEPS = 100;
    localparam int DUTY_MIN = 1;
    localparam int DIM_STEP_CYC = int'($floor(CLK_HZ / (DIM_PWM_HZ * 100.0)));
    localparam int DUTY_BITS = 7;
    localparam int STEP_BITS = 16;

    // ****************************************************************
    // Carriers and states
    // ****************************************************************
    typedef struct packed {
        logic [PIXEL_BITS-1:0] oddPixel;
        logic [PIXEL_BITS-1:0] evenPixel;
    } pixel_pair_t;

    typedef struct packed {
        logic dataEnable;
        pixel_pair_t pixels;
    } link_port_t;

    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_SUPPLY = 8'h02,
        ST_VIDEO = 8'h04,
        ST_LIGHT_WAIT = 8'h08,
        ST_LIT = 8'h10,
        ST_DIM_WAIT = 8'h20,
        ST_LINK_WAIT = 8'h40,
        ST_DISCHARGE = 8'h80
    } power_state_t;

endpackage

// >>> src/panel_link_host.sv
// Summary of operation
// - Port clock 59.4 to 77.34 MHz across 48 to 62.5 Hz frame rates.
// - 960 active clocks per port per line, blanking 86 to 214 clocks.
// - 1080 active lines per frame, blanking 12 to 300 lines.
// - Any clock spreading stays 60 to 200 kHz and within 2 percent.
// - Clock spreading stays off unless fully validated with the panel.
// - With panel supply off, every interface signal is held low.
// - With panel supply on, all interface signals are actively driven.
// - Wait at least 1000.0 ms after power-down before supply returns.
// - Backlight on after valid video starts, off before video stops.
// - Dimming is a pulse-width signal, 0.1 to 20 kHz, duty 1 to 100 percent.
// - Two ports, four data pairs and a forwarded clock each, odd and even.
`timescale 1ns/1ps
`default_nettype none

module panel_link_host
    import panel_link_pkg::*;
#(
    parameter int LINE_BLANK = LINE_BLANK_TYP,
    parameter int FRAME_BLANK = FRAME_BLANK_TYP,
    parameter int SUPPLY_CYC = SUPPLY_RISE_CYC,
    parameter int LIGHT_CYC = LIGHT_DELAY_CYC,
    parameter int DIM_CYC = DIM_DELAY_CYC,
    parameter int STOP_CYC = LINK_STOP_CYC,
    parameter int OFF_CYC = POWER_OFF_CYC,
    parameter int STEP_CYC = DIM_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic pixClk,
    input wire logic powerRequest,
    input wire logic [DUTY_BITS-1:0] backlightDimmingDuty,
    input wire pixel_pair_t pixelIn,
    output logic pixelRequest,
    output logic frameStart,
    output link_port_t linkOut,
    output logic oddPortClockGate,
    output logic evenPortClockGate,
    output logic panelSupplyEn,
    output logic backlightEn,
    output logic backlightDimmingInput,
    output logic powerBusy
);

    // ****************************************************************
    // Control domain: power sequencing
    // ****************************************************************
    power_state_t state_ff;
    power_state_t nxt_state;
    logic [WAIT_BITS-1:0] wait_ff;
    logic supply_ff;
    logic linkRun_ff;
    logic light_ff;
    logic vidMeta_ff;
    logic vidSync_ff;
    logic vidLink_ff;
    logic busy_ff;
    logic [WAIT_BITS-1:0] waitLimit;
    logic waitDone;
    logic stateChange;
    logic videoValid;

    // Wait length per state; every wait is a least time
    assign waitLimit =
        (state_ff == ST_SUPPLY) ? WAIT_BITS'(SUPPLY_CYC) :
        (state_ff == ST_LIGHT_WAIT) ? WAIT_BITS'(LIGHT_CYC) :
        (state_ff == ST_DIM_WAIT) ? WAIT_BITS'(DIM_CYC) :
        (state_ff == ST_LINK_WAIT) ? WAIT_BITS'(STOP_CYC) :
        WAIT_BITS'(OFF_CYC);
    assign waitDone = (wait_ff >= waitLimit - WAIT_BITS'(1));
    assign videoValid = vidSync_ff;
    assign stateChange = (nxt_state != state_ff);

    // Next-state decode
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (powerRequest) begin
                    nxt_state = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                if (waitDone) begin
                    nxt_state = ST_VIDEO;
                end
            end
            ST_VIDEO: begin
                if (!powerRequest) begin
                    nxt_state = ST_LINK_WAIT;
                end else if (videoValid) begin
                    nxt_state = ST_LIGHT_WAIT;
                end
            end
            ST_LIGHT_WAIT: begin
                if (!powerRequest) begin
                    nxt_state = ST_LINK_WAIT;
                end else if (waitDone) begin
                    nxt_state = ST_LIT;
                end
            end
            ST_LIT: begin
                if (!powerRequest) begin
                    nxt_state = ST_DIM_WAIT;
                end
            end
            ST_DIM_WAIT: begin
                if (waitDone) begin
                    nxt_state = ST_LINK_WAIT;
                end
            end
            ST_LINK_WAIT: begin
                if (waitDone) begin
                    nxt_state = ST_DISCHARGE;
                end
            end
            ST_DISCHARGE: begin
                if (waitDone) begin
                    nxt_state = ST_OFF;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    // Sequencer state and wait counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_OFF;
            wait_ff <= '0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            wait_ff <= stateChange ? '0 : wait_ff + WAIT_BITS'(1);
        end
    end

    // Supply, link and backlight levels follow the state
    logic nxt_supply;
    logic nxt_linkRun;
    logic nxt_light;
    assign nxt_supply = (nxt_state != ST_OFF) && (nxt_state != ST_DISCHARGE);
    assign nxt_linkRun = (nxt_state == ST_VIDEO) ||
        (nxt_state == ST_LIGHT_WAIT) || (nxt_state == ST_LIT) ||
        (nxt_state == ST_DIM_WAIT);
    assign nxt_light = (nxt_state == ST_LIT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_ff <= 1'b0;
            linkRun_ff <= 1'b0;
            light_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (clkEn) begin
            supply_ff <= nxt_supply;
            linkRun_ff <= nxt_linkRun;
            light_ff <= nxt_light;
            busy_ff <= (nxt_state != ST_OFF) && (nxt_state != ST_LIT);
        end
    end

    // Video-valid level from the link side, two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vidMeta_ff <= 1'b0;
            vidSync_ff <= 1'b0;
        end else if (clkEn) begin
            vidMeta_ff <= vidLink_ff;
            vidSync_ff <= vidMeta_ff;
        end
    end

    assign panelSupplyEn = supply_ff;
    assign backlightEn = light_ff;
    assign powerBusy = busy_ff;

    // ****************************************************************
    // Control domain: backlight dimming
    // ****************************************************************
    logic [STEP_BITS-1:0] step_ff;
    logic [DUTY_BITS-1:0] pct_ff;
    logic pwm_ff;
    logic [DUTY_BITS-1:0] dutyClamped;
    logic stepWrap;
    logic pctWrap;

    // Out-of-range duty is pulled into 1..100 so the lamp never goes dark while lit
    assign dutyClamped =
        (backlightDimmingDuty < DUTY_BITS'(DUTY_MIN)) ? DUTY_BITS'(DUTY_MIN) :
        (backlightDimmingDuty > DUTY_BITS'(DUTY_STEPS)) ?
            DUTY_BITS'(DUTY_STEPS) : backlightDimmingDuty;
    assign stepWrap = (step_ff == STEP_BITS'(STEP_CYC - 1));
    assign pctWrap = (pct_ff == DUTY_BITS'(DUTY_STEPS - 1));

    // Percent-step counter; 100 steps of STEP_CYC make one period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_ff <= '0;
            pct_ff <= '0;
            pwm_ff <= 1'b0;
        end else if (clkEn) begin
            step_ff <= stepWrap ? '0 : step_ff + STEP_BITS'(1);
            if (stepWrap) begin
                pct_ff <= pctWrap ? '0 : pct_ff + DUTY_BITS'(1);
            end
            pwm_ff <= nxt_light && (pct_ff < dutyClamped);
        end
    end

    assign backlightDimmingInput = pwm_ff;

    // ****************************************************************
    // Link domain: reset, enable and run crossings
    // ****************************************************************
    logic rstMeta_ff;
    logic rstLink_ff;
    logic enMeta_ff;
    logic enLink_ff;
    logic runMeta_ff;
    logic runLink_ff;

    // Reset asserts at once and releases on a pixel clock edge
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) begin
            rstMeta_ff <= 1'b1;
            rstLink_ff <= 1'b1;
        end else begin
            rstMeta_ff <= 1'b0;
            rstLink_ff <= rstMeta_ff;
        end
    end

    // Enable and run are levels, so two flops carry them
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) begin
            enMeta_ff <= 1'b0;
            enLink_ff <= 1'b0;
            runMeta_ff <= 1'b0;
            runLink_ff <= 1'b0;
        end else begin
            enMeta_ff <= clkEn;
            enLink_ff <= enMeta_ff;
            runMeta_ff <= linkRun_ff;
            runLink_ff <= runMeta_ff;
        end
    end

    // ****************************************************************
    // Link domain: line and frame counters
    // ****************************************************************
    logic [HCOUNT_BITS-1:0] hCount_ff;
    logic [VCOUNT_BITS-1:0] vCount_ff;
    logic lineEnd;
    logic frameEnd;
    logic activeNow;
    logic frameFirst;

    assign lineEnd = (hCount_ff ==
        HCOUNT_BITS'(LINE_ACTIVE_CLOCKS + LINE_BLANK - 1));
    assign frameEnd = (vCount_ff ==
        VCOUNT_BITS'(FRAME_ACTIVE_LINES + FRAME_BLANK - 1));
    // Only window, no syncs: the panel frames from this alone
    assign activeNow = runLink_ff &&
        (hCount_ff < HCOUNT_BITS'(LINE_ACTIVE_CLOCKS)) &&
        (vCount_ff < VCOUNT_BITS'(FRAME_ACTIVE_LINES));
    assign frameFirst = runLink_ff && (hCount_ff == '0) && (vCount_ff == '0);

    // Counters restart from the frame top whenever the link is stopped
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) begin
            hCount_ff <= '0;
            vCount_ff <= '0;
        end else if (rstLink_ff || !runLink_ff) begin
            hCount_ff <= '0;
            vCount_ff <= '0;
        end else if (enLink_ff) begin
            hCount_ff <= lineEnd ? '0 : hCount_ff + HCOUNT_BITS'(1);
            if (lineEnd) begin
                vCount_ff <= frameEnd ? '0 : vCount_ff + VCOUNT_BITS'(1);
            end
        end
    end

    // Video counts as valid once one full frame has gone out
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) begin
            vidLink_ff <= 1'b0;
        end else if (rstLink_ff || !runLink_ff) begin
            vidLink_ff <= 1'b0;
        end else if (enLink_ff && lineEnd && frameEnd) begin
            vidLink_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // Link domain: pixel request and port outputs
    // ****************************************************************
    logic req_ff;
    logic frame_ff;
    logic gate_ff;
    link_port_t port_ff;
    link_port_t nxt_port;

    // Both halves share one enable and one clock edge, odd pixel first
    assign nxt_port.dataEnable = req_ff;
    assign nxt_port.pixels.oddPixel =
        req_ff ? pixelIn.oddPixel : '0;
    assign nxt_port.pixels.evenPixel =
        req_ff ? pixelIn.evenPixel : '0;

    // Stopped link holds everything low rather than floating
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) begin
            req_ff <= 1'b0;
            frame_ff <= 1'b0;
            gate_ff <= 1'b0;
            port_ff <= '0;
        end else if (rstLink_ff || !runLink_ff) begin
            req_ff <= 1'b0;
            frame_ff <= 1'b0;
            gate_ff <= 1'b0;
            port_ff <= '0;
        end else if (enLink_ff) begin
            req_ff <= activeNow;
            frame_ff <= frameFirst;
            gate_ff <= 1'b1;
            port_ff <= nxt_port;
        end
    end

    assign pixelRequest = req_ff;
    assign frameStart = frame_ff;
    assign linkOut = port_ff;
    // Clock is forwarded unmodulated; totals sized for 60 Hz typ
    assign oddPortClockGate = gate_ff;
    assign evenPortClockGate = gate_ff;

endmodule // panel_link_host

`default_nettype wire

// >>> sim/panel_link_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checks of the host sequencer
// ****************************************
module panel_link_host_checker
    import panel_link_pkg::*;
#(
    parameter int OFF_CYC = POWER_OFF_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic pixClk,
    input wire logic powerRequest,
    input wire pixel_pair_t pixelIn,
    input wire logic pixelRequest,
    input wire logic frameStart,
    input wire link_port_t linkOut,
    input wire logic oddPortClockGate,
    input wire logic evenPortClockGate,
    input wire logic panelSupplyEn,
    input wire logic backlightEn,
    input wire logic backlightDimmingInput,
    input wire logic powerBusy
);
    logic [WAIT_BITS-1:0] offCnt_ff;
    logic [WAIT_BITS-1:0] nxt_offCnt;
    logic [HCOUNT_BITS-1:0] reqRun_ff;
    logic [HCOUNT_BITS-1:0] nxt_reqRun;
    // Saturating off time; starts full since reset counts as long off
    assign nxt_offCnt = panelSupplyEn ? '0
        : ((&offCnt_ff) ? offCnt_ff : offCnt_ff + 1'b1);
    assign nxt_reqRun = pixelRequest ? reqRun_ff + 1'b1 : '0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) offCnt_ff <= '1;
        else offCnt_ff <= nxt_offCnt;
    end
    // Length of the current request run
    always_ff @(posedge pixClk or posedge rst) begin
        if (rst) reqRun_ff <= '0;
        else reqRun_ff <= nxt_reqRun;
    end
    supply_on_a: assert property (@(posedge clk) disable iff (rst)
        clkEn && powerRequest && !powerBusy && !panelSupplyEn
        |=> panelSupplyEn && powerBusy) else $error("supply late");
    off_wait_a: assert property (@(posedge clk) disable iff (rst)
        $rose(panelSupplyEn) |-> offCnt_ff >= OFF_CYC)
        else $error("supply back too soon");
    link_quiet_a: assert property (@(posedge pixClk) disable iff (rst)
        !panelSupplyEn |-> linkOut == '0 && !oddPortClockGate)
        else $error("link active without supply");
    light_order_a: assert property (@(posedge clk) disable iff (rst)
        backlightEn |-> panelSupplyEn && oddPortClockGate)
        else $error("backlight without video");
    dim_off_a: assert property (@(posedge clk) disable iff (rst)
        !backlightEn |-> !backlightDimmingInput) else $error("dim while dark");
    de_follow_a: assert property (@(posedge pixClk) disable iff (rst)
        pixelRequest && powerRequest |=> linkOut.dataEnable
        && linkOut.pixels == $past(pixelIn)) else $error("pixel lost");
    de_only_a: assert property (@(posedge pixClk) disable iff (rst)
        linkOut.dataEnable |-> $past(pixelRequest)) else $error("stray enable");
    blank_zero_a: assert property (@(posedge pixClk) disable iff (rst)
        !linkOut.dataEnable |-> linkOut.pixels == '0) else $error("blank data");
    lockstep_a: assert property (@(posedge pixClk) disable iff (rst)
        oddPortClockGate == evenPortClockGate) else $error("ports apart");
    line_len_a: assert property (@(posedge pixClk) disable iff (rst)
        $fell(pixelRequest) && oddPortClockGate
        |-> reqRun_ff == LINE_ACTIVE_CLOCKS) else $error("line length");
    frame_first_a: assert property (@(posedge pixClk) disable iff (rst)
        frameStart |-> pixelRequest) else $error("frame start off");
    // Main scenarios reached
    cover property (@(posedge clk) $rose(panelSupplyEn));
    cover property (@(posedge clk) $fell(panelSupplyEn));
    cover property (@(posedge pixClk) frameStart);
    cover property (@(posedge pixClk) $fell(pixelRequest));
endmodule // panel_link_host_checker

bind panel_link_host panel_link_host_checker #(.OFF_CYC(OFF_CYC)) chk (
    .clk(clk), .rst(rst), .clkEn(clkEn), .pixClk(pixClk),
    .powerRequest(powerRequest), .pixelIn(pixelIn),
    .pixelRequest(pixelRequest), .frameStart(frameStart), .linkOut(linkOut),
    .oddPortClockGate(oddPortClockGate),
    .evenPortClockGate(evenPortClockGate), .panelSupplyEn(panelSupplyEn),
    .backlightEn(backlightEn), .backlightDimmingInput(backlightDimmingInput),
    .powerBusy(powerBusy)
);
`default_nettype wire

// >>> sim/panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Panel receiver model, enable-window only
// ****************************************
module panel_model
    import panel_link_pkg::*;
(
    input wire logic pixClk,
    input wire logic rst,
    input wire link_port_t linkOut,
    input wire logic oddPortClockGate,
    input wire logic evenPortClockGate,
    output logic [15:0] lineCount,
    output logic [15:0] lastActive,
    output logic [15:0] lastBlank,
    output logic [15:0] pairErrs,
    output logic [15:0] lockErrs
);
    logic [15:0] actRun;
    logic [15:0] idleRun;
    logic deSeen;
    logic [PIXEL_BITS-1:0] expOdd;
    assign expOdd = PIXEL_BITS'({actRun, 1'b0});
    // No sync inputs exist; lines are framed by enable edges alone
    always @(posedge pixClk or posedge rst) begin
        if (rst) begin
            {lineCount, lastActive, lastBlank, pairErrs, lockErrs} <= '0;
            {actRun, idleRun, deSeen} <= '0;
        end else if (oddPortClockGate) begin
            deSeen <= linkOut.dataEnable;
            if (linkOut.dataEnable) begin
                actRun <= actRun + 16'h0001;
                if (linkOut.pixels.oddPixel != expOdd
                    || linkOut.pixels.evenPixel != expOdd + 1'b1) begin
                    pairErrs <= pairErrs + 16'h0001;
                end
            end else begin
                idleRun <= idleRun + 16'h0001;
            end
            if (linkOut.dataEnable && !deSeen) begin
                lastBlank <= idleRun;
                idleRun <= '0;
                lineCount <= lineCount + 16'h0001;
            end
            if (!linkOut.dataEnable && deSeen) begin
                lastActive <= actRun;
                actRun <= '0;
            end
        end
        // Both forwarded clocks must run together
        if (!rst && oddPortClockGate != evenPortClockGate) begin
            lockErrs <= lockErrs + 16'h0001;
        end
    end
endmodule // panel_model
`default_nettype wire

// >>> sim/panel_link_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
    checkCount++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
// ****************************************
// Bench for the panel link host
// ****************************************
module panel_link_host_tb_top
    import panel_link_pkg::*;
;
    localparam int SUP_T = 20;
    localparam int OFF_T = 50;
    logic clk, rst, clkEn, pixClk, powerRequest;
    logic [DUTY_BITS-1:0] backlightDimmingDuty;
    pixel_pair_t pixelIn;
    link_port_t linkOut;
    logic pixelRequest, frameStart, oddPortClockGate, evenPortClockGate;
    logic panelSupplyEn, backlightEn, backlightDimmingInput, powerBusy;
    logic [15:0] lineCount, lastActive, lastBlank, pairErrs, lockErrs;
    int miscompares = 0;
    int checkCount = 0;
    int cycles = 0;
    int n;

    panel_link_host #(.LINE_BLANK(LINE_BLANK_MIN),
        .FRAME_BLANK(FRAME_BLANK_MIN), .SUPPLY_CYC(SUP_T),
        .LIGHT_CYC(30), .DIM_CYC(10), .STOP_CYC(10), .OFF_CYC(OFF_T),
        .STEP_CYC(2)) uut (
        .clk(clk), .rst(rst), .clkEn(clkEn), .pixClk(pixClk),
        .powerRequest(powerRequest),
        .backlightDimmingDuty(backlightDimmingDuty), .pixelIn(pixelIn),
        .pixelRequest(pixelRequest), .frameStart(frameStart),
        .linkOut(linkOut), .oddPortClockGate(oddPortClockGate),
        .evenPortClockGate(evenPortClockGate), .panelSupplyEn(panelSupplyEn),
        .backlightEn(backlightEn),
        .backlightDimmingInput(backlightDimmingInput), .powerBusy(powerBusy));
    panel_model model (.pixClk(pixClk), .rst(rst), .linkOut(linkOut),
        .oddPortClockGate(oddPortClockGate),
        .evenPortClockGate(evenPortClockGate), .lineCount(lineCount),
        .lastActive(lastActive), .lastBlank(lastBlank),
        .pairErrs(pairErrs), .lockErrs(lockErrs));

    // Clocks; periods differ so phases drift freely
    always #50 clk = ~clk;
    always #24 pixClk = ~pixClk;
    // Source numbers pixels per line so pairing is visible at the panel
    always @(posedge pixClk) begin
        if (pixelRequest === 1'b1) begin
            pixelIn.oddPixel <= pixelIn.oddPixel + 24'h000002;
            pixelIn.evenPixel <= pixelIn.evenPixel + 24'h000002;
        end else begin
            pixelIn <= {24'h000000, 24'h000001};
        end
    end
    // Ceiling well above the expected eleven hundred or so cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic testIdle();
        repeat (3) @(posedge clk);
        #1;
        `CHECK(panelSupplyEn, 1'b0)
        `CHECK(linkOut, '0)
        `CHECK(oddPortClockGate, 1'b0)
        `CHECK(backlightEn, 1'b0)
        $display("testIdle done");
    endtask

    task automatic testPowerUp();
        @(posedge clk);
        powerRequest <= 1'b1;
        @(posedge clk);
        #1;
        `CHECK(panelSupplyEn, 1'b1)
        `CHECK(powerBusy, 1'b1)
        // Freeze the sequencer; the supply wait must stretch by as long
        @(posedge clk);
        clkEn <= 1'b0;
        repeat (10) @(posedge clk);
        clkEn <= 1'b1;
        #1;
        `CHECK(panelSupplyEn, 1'b1)
        `CHECK(oddPortClockGate, 1'b0)
        n = 0;
        while (oddPortClockGate !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(n >= SUP_T - 1, 1'b1)
        `CHECK(evenPortClockGate, 1'b1)
        $display("testPowerUp done");
    endtask

    task automatic testLines();
        n = 0;
        while (lineCount < 16'h0003 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(lineCount, 16'h0003)
        `CHECK(lastActive, 16'(LINE_ACTIVE_CLOCKS))
        `CHECK(lastBlank, 16'(LINE_BLANK_MIN))
        `CHECK(pairErrs, 16'h0000)
        `CHECK(lockErrs, 16'h0000)
        `CHECK(backlightEn, 1'b0)
        $display("testLines done");
    endtask

    task automatic testPowerDown();
        @(posedge clk);
        powerRequest <= 1'b0;
        n = 0;
        while (panelSupplyEn === 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(panelSupplyEn, 1'b0)
        `CHECK(oddPortClockGate, 1'b0)
        `CHECK(linkOut, '0)
        // Request again at once; must wait out the discharge
        @(posedge clk);
        powerRequest <= 1'b1;
        n = 0;
        while (panelSupplyEn !== 1'b1 && n < 500) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(panelSupplyEn, 1'b1)
        `CHECK(n >= OFF_T, 1'b1)
        $display("testPowerDown done");
    endtask

    initial begin
        clk = 1'b0;
        pixClk = 1'b0;
        rst = 1'b1;
        clkEn = 1'b1;
        powerRequest = 1'b0;
        backlightDimmingDuty = 7'h32;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        testIdle();
        testPowerUp();
        testLines();
        testPowerDown();
        conclude();
    end
endmodule // panel_link_host_tb_top
`default_nettype wire
